// ### common/hbm_pkg.sv
// Purpose: shared constants and types for the host bus port
// Assumes: one bus clock domain at 100 MHz
// Notes: widths and most values after reset live here; SYNC_RST is set in the port
package hbm_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int HBM_IDX_W = 6;
    localparam int HBM_ADDR_W = 32;
    localparam int HBM_IRQ_W = 16;
    localparam int HBM_SYNC_STAGES = 2;

    // ****************************************
    // host spacing between select and request
    // ****************************************
    localparam int HBM_CS_SHARED_MEM_REQUEST_N_GAP = 2;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic HBM_RST_STROBE_N = 1'b1;
    localparam logic HBM_RST_LOW = 1'b0;
    localparam logic [HBM_IDX_W-1:0] HBM_RST_IDX = 6'h00;
    localparam logic [HBM_ADDR_W-1:0] HBM_RST_ADDR = 32'h0000_0000;

    // ****************************************
    // state types
    // ****************************************
    typedef enum logic [1:0] {
        HBM_M_IDLE,
        HBM_M_REQ,
        HBM_M_T1,
        HBM_M_T2
    } hbm_mstate_t;

    typedef enum logic [1:0] {
        HBM_OWN_NONE,
        HBM_OWN_HOST,
        HBM_OWN_LOCAL
    } hbm_owner_t;

endpackage : hbm_pkg

// ### hw/hbm_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous levels, not pulses
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module hbm_sync
    import hbm_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // pins in, levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // hbm_sync
`default_nettype wire

// ### hw/hbm_host_port.sv
// Purpose: host bus port: master strobes, bus request, slave acknowledge,
//          shared buffer arbiter and interrupt pin
// Assumes: host pins are asynchronous; dma and register logic share CLK_SYS
// Notes: the early cycle start strobe is low for the whole first bus state
`timescale 1ns/1ps
`default_nettype none
module hbm_host_port
    import hbm_pkg::*;
#(
    parameter int IRQ_W = HBM_IRQ_W
) (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic CE,
    // host slave pins
    input wire logic REG_SELECT_N,
    input wire logic SHARED_MEM_REQUEST_N,
    input wire logic SLAVE_INDEX_LATCH_N,
    input wire logic SLAVE_DIR_IN,
    input wire logic [HBM_IDX_W-1:0] REG_INDEX_BUS,
    output logic SLAVE_MEM_ACKNOWLEDGE_N,
    // bus master pins
    input wire logic BUS_GRANT_IN,
    input wire logic BUS_PROTOCOL_SELECT,
    output logic BUS_REQUEST_OUT,
    output logic EARLY_CYCLE_START_N,
    output logic EARLY_CYCLE_START_OE,
    output logic ADDR_VALID_STROBE_N,
    output logic ADDR_VALID_STROBE_OE,
    output logic MASTER_DIR_STROBE,
    output logic MASTER_DIR_STROBE_OE,
    output logic [HBM_ADDR_W-1:0] MASTER_ADDR,
    output logic MASTER_ADDR_OE,
    output logic GRANT_ACK_OUT_N,
    output logic GRANT_ACK_OUT_OE,
    // interrupt pin
    output logic INTERRUPT_N,
    // internal dma engine
    input wire logic DMA_REQ,
    input wire logic DMA_WRITE,
    input wire logic DMA_LAST,
    input wire logic [HBM_ADDR_W-1:0] DMA_ADDR,
    output logic DMA_CYCLE_DONE,
    // internal register file
    input wire logic REG_READY,
    output logic [HBM_IDX_W-1:0] REG_INDEX,
    output logic REG_READ_STB,
    output logic REG_WRITE_STB,
    // internal buffer ram user
    input wire logic LBUF_REQ,
    output logic LBUF_GNT,
    output logic HOST_BUF_GNT,
    // interrupt sources
    input wire logic [IRQ_W-1:0] IRQ_STATUS,
    input wire logic [IRQ_W-1:0] IRQ_MASK
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int SYNC_W = HBM_IDX_W + 6;
    localparam logic [SYNC_W-1:0] SYNC_RST = {6'h38, HBM_RST_IDX};

    logic [SYNC_W-1:0] sync_q;
    wire logic cs_act;
    wire logic shared_mem_request_n_act;
    wire logic sas_act;
    wire logic dir_s;
    wire logic grant_s;
    wire logic mode_s;
    wire logic [HBM_IDX_W-1:0] idx_s;

    // select lines reset as inactive (high), grant and mode as low
    hbm_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk(CLK_SYS),
        .rst(RESET),
        .ce(CE),
        .d({REG_SELECT_N, SHARED_MEM_REQUEST_N, SLAVE_INDEX_LATCH_N,
            SLAVE_DIR_IN, BUS_GRANT_IN, BUS_PROTOCOL_SELECT, REG_INDEX_BUS}),
        .q(sync_q)
    );

    assign cs_act = !sync_q[SYNC_W-1];
    assign shared_mem_request_n_act = !sync_q[SYNC_W-2];
    assign sas_act = !sync_q[SYNC_W-3];
    assign dir_s = sync_q[SYNC_W-4];
    assign grant_s = sync_q[SYNC_W-5];
    assign mode_s = sync_q[SYNC_W-6];
    assign idx_s = sync_q[HBM_IDX_W-1:0];

    // ****************************************
    // slave side: index latch and register acknowledge
    // ****************************************
    logic sas_prev_r;
    logic reg_ack_r;
    logic [HBM_IDX_W-1:0] idx_r;
    logic rd_stb_r;
    logic wr_stb_r;
    wire logic sas_edge;
    wire logic reg_ok;
    wire logic reg_first;

    assign sas_edge = sas_act && !sas_prev_r;
    // mutual exclusion with memory request is the host's duty; guard anyway
    assign reg_ok = cs_act && !shared_mem_request_n_act && REG_READY;
    assign reg_first = reg_ok && !reg_ack_r;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            sas_prev_r <= HBM_RST_LOW;
            idx_r <= HBM_RST_IDX;
            reg_ack_r <= HBM_RST_LOW;
            rd_stb_r <= HBM_RST_LOW;
            wr_stb_r <= HBM_RST_LOW;
        end else if (CE) begin
            sas_prev_r <= sas_act;
            if (sas_edge) begin
                idx_r <= idx_s;
            end
            reg_ack_r <= reg_ok;
            rd_stb_r <= reg_first && !dir_s;
            wr_stb_r <= reg_first && dir_s;
        end
    end

    // ****************************************
    // shared buffer arbiter
    // ****************************************
    hbm_owner_t owner_r;
    hbm_owner_t owner_nxt;
    logic host_gnt_r;
    logic lbuf_gnt_r;

    // host wins a tie: its cycle is already stretched by the synchroniser
    always_comb begin
        owner_nxt = owner_r;
        unique case (owner_r)
            HBM_OWN_NONE: begin
                if (shared_mem_request_n_act && !cs_act) begin
                    owner_nxt = HBM_OWN_HOST;
                end else if (LBUF_REQ) begin
                    owner_nxt = HBM_OWN_LOCAL;
                end
            end
            HBM_OWN_HOST: begin
                if (!shared_mem_request_n_act) begin
                    owner_nxt = HBM_OWN_NONE;
                end
            end
            HBM_OWN_LOCAL: begin
                if (!LBUF_REQ) begin
                    owner_nxt = HBM_OWN_NONE;
                end
            end
            default: owner_nxt = HBM_OWN_NONE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            owner_r <= HBM_OWN_NONE;
            host_gnt_r <= HBM_RST_LOW;
            lbuf_gnt_r <= HBM_RST_LOW;
        end else if (CE) begin
            owner_r <= owner_nxt;
            host_gnt_r <= (owner_nxt == HBM_OWN_HOST);
            lbuf_gnt_r <= (owner_nxt == HBM_OWN_LOCAL);
        end
    end

    // ****************************************
    // bus master sequencer
    // ****************************************
    hbm_mstate_t mst_r;
    hbm_mstate_t mst_nxt;
    logic hold_r;
    logic ecs_n_r;
    logic ads_n_r;
    logic drive_r;
    logic dir_r;
    logic done_r;
    logic [HBM_ADDR_W-1:0] addr_r;
    wire logic enter_t1;

    always_comb begin
        mst_nxt = mst_r;
        unique case (mst_r)
            // a stale synchronised grant from the last burst must not
            // start a cycle: wait until the arbiter has withdrawn it
            HBM_M_IDLE: begin
                if (DMA_REQ && !grant_s) begin
                    mst_nxt = HBM_M_REQ;
                end
            end
            HBM_M_REQ: if (grant_s) mst_nxt = HBM_M_T1;
            HBM_M_T1: mst_nxt = HBM_M_T2;
            HBM_M_T2: begin
                if (DMA_LAST || !DMA_REQ || !grant_s) begin
                    mst_nxt = HBM_M_IDLE;
                end else begin
                    mst_nxt = HBM_M_T1;
                end
            end
        endcase
    end

    assign enter_t1 = (mst_nxt == HBM_M_T1);

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            mst_r <= HBM_M_IDLE;
            hold_r <= HBM_RST_LOW;
            ecs_n_r <= HBM_RST_STROBE_N;
            ads_n_r <= HBM_RST_STROBE_N;
            drive_r <= HBM_RST_LOW;
            dir_r <= HBM_RST_LOW;
            done_r <= HBM_RST_LOW;
            addr_r <= HBM_RST_ADDR;
        end else if (CE) begin
            mst_r <= mst_nxt;
            hold_r <= (mst_nxt != HBM_M_IDLE);
            ecs_n_r <= !enter_t1;
            // low through T1, rising into T2 marks address valid
            ads_n_r <= !enter_t1;
            drive_r <= enter_t1 || (mst_nxt == HBM_M_T2);
            done_r <= (mst_r == HBM_M_T2);
            if (enter_t1) begin
                dir_r <= DMA_WRITE;
                addr_r <= DMA_ADDR;
            end
        end
    end

    // ****************************************
    // interrupt and grant acknowledge pins
    // ****************************************
    logic int_n_r;
    logic gack_oe_r;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            int_n_r <= HBM_RST_STROBE_N;
            gack_oe_r <= HBM_RST_LOW;
        end else if (CE) begin
            int_n_r <= !(|(IRQ_STATUS & IRQ_MASK));
            gack_oe_r <= mode_s && (mst_nxt != HBM_M_IDLE)
                && grant_s;
        end
    end

    // ****************************************
    // outputs, straight from flops except the ORed acknowledge and the tied-low GRANT_ACK_OUT_N
    // ****************************************
    assign SLAVE_MEM_ACKNOWLEDGE_N = !(reg_ack_r || host_gnt_r);
    assign BUS_REQUEST_OUT = hold_r;
    assign EARLY_CYCLE_START_N = ecs_n_r;
    assign EARLY_CYCLE_START_OE = drive_r;
    assign ADDR_VALID_STROBE_N = ads_n_r;
    assign ADDR_VALID_STROBE_OE = drive_r;
    assign MASTER_DIR_STROBE = dir_r;
    assign MASTER_DIR_STROBE_OE = drive_r;
    assign MASTER_ADDR = addr_r;
    assign MASTER_ADDR_OE = drive_r;
    assign GRANT_ACK_OUT_N = HBM_RST_LOW;
    assign GRANT_ACK_OUT_OE = gack_oe_r;
    assign INTERRUPT_N = int_n_r;
    assign DMA_CYCLE_DONE = done_r;
    assign REG_INDEX = idx_r;
    assign REG_READ_STB = rd_stb_r;
    assign REG_WRITE_STB = wr_stb_r;
    assign LBUF_GNT = lbuf_gnt_r;
    assign HOST_BUF_GNT = host_gnt_r;

    // ****************************************
    // checks
    // ****************************************
    chk_ecs_in_t1: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        $fell(EARLY_CYCLE_START_N) |=> $rose(EARLY_CYCLE_START_N)
            && EARLY_CYCLE_START_OE)
        else $error("early cycle start not one cycle long");

    chk_ads_rise_valid: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        $rose(ADDR_VALID_STROBE_N) && ADDR_VALID_STROBE_OE
            |-> $stable(MASTER_ADDR) && $stable(MASTER_DIR_STROBE))
        else $error("address changed at strobe rising edge");

    chk_dir_follows: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        $fell(EARLY_CYCLE_START_N) |-> MASTER_DIR_STROBE == $past(DMA_WRITE))
        else $error("direction strobe does not match cycle kind");

    chk_drive_granted: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        $rose(ADDR_VALID_STROBE_OE) |-> BUS_REQUEST_OUT && $past(grant_s))
        else $error("bus driven without grant");

    chk_hold_idle: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        mst_r == HBM_M_IDLE && !DMA_REQ |=> !BUS_REQUEST_OUT)
        else $error("bus request high with nothing pending");

    chk_int_masked: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        !(|(IRQ_STATUS & IRQ_MASK)) |=> INTERRUPT_N)
        else $error("masked source drove interrupt");

    chk_arb_exclusive: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        !(LBUF_GNT && HOST_BUF_GNT))
        else $error("buffer granted to both parties");

    chk_ack_cause: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        $fell(SLAVE_MEM_ACKNOWLEDGE_N)
            |-> $past(reg_ok) || ($past(shared_mem_request_n_act) && HOST_BUF_GNT))
        else $error("acknowledge without access available");

    chk_index_latch: assert property (@(posedge CLK_SYS)
        disable iff (RESET || !CE)
        sas_edge |=> REG_INDEX == $past(idx_s))
        else $error("register index not latched");

endmodule // hbm_host_port
`default_nettype wire

// ### sim/hbm_arb_model.sv
// Purpose: system bus arbiter standing beside the host port
// Assumes: request and grant are levels on the bus clock
// Notes: grant wait is set per burst to try prompt and slow answers
`timescale 1ns/1ps
`default_nettype none
module hbm_arb_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request in, grant out
    input wire logic bus_req,
    input wire logic [3:0] delay,
    output logic grant
);
    logic [3:0] cnt_r;
    // grant is withdrawn as soon as the request drops
    always_ff @(posedge clk) begin
        if (rst || !bus_req) begin
            grant <= 1'b0;
            cnt_r <= 4'h0;
        end else if (cnt_r >= delay) begin
            grant <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // hbm_arb_model
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench for the host bus port
// Assumes: bench plays host and dma; arbiter model answers requests
// Notes: fixed seed, random values mixed with corner cases
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hbm_pkg::*;
    logic CLK_SYS = 1'b0, RESET = 1'b1, CE = 1'b1, REG_READY = 1'b0;
    logic REG_SELECT_N = 1'b1, SHARED_MEM_REQUEST_N = 1'b1;
    logic SLAVE_INDEX_LATCH_N = 1'b1, SLAVE_DIR_IN = 1'b0;
    logic [HBM_IDX_W-1:0] REG_INDEX_BUS = 6'h00;
    logic BUS_PROTOCOL_SELECT = 1'b0, BUS_GRANT_IN;
    logic DMA_REQ = 1'b0, DMA_WRITE = 1'b0, DMA_LAST = 1'b0;
    logic [HBM_ADDR_W-1:0] DMA_ADDR = 32'h0, MASTER_ADDR;
    logic LBUF_REQ = 1'b0, LBUF_GNT, HOST_BUF_GNT;
    logic [HBM_IRQ_W-1:0] IRQ_STATUS = 16'h0, IRQ_MASK = 16'h0;
    logic SLAVE_MEM_ACKNOWLEDGE_N, BUS_REQUEST_OUT, INTERRUPT_N;
    logic EARLY_CYCLE_START_N, EARLY_CYCLE_START_OE, DMA_CYCLE_DONE;
    logic ADDR_VALID_STROBE_N, ADDR_VALID_STROBE_OE;
    logic MASTER_DIR_STROBE, MASTER_DIR_STROBE_OE, MASTER_ADDR_OE;
    logic GRANT_ACK_OUT_N, GRANT_ACK_OUT_OE, REG_READ_STB, REG_WRITE_STB;
    logic [HBM_IDX_W-1:0] REG_INDEX;
    logic [3:0] arb_delay = 4'h0;
    int n_mismatch = 0, check_count = 0, cyc = 0, k;
    logic [31:0] ra, rb;

    hbm_host_port #(.IRQ_W(HBM_IRQ_W)) u_dut (.*);
    hbm_arb_model u_arb (.clk(CLK_SYS), .rst(RESET),
        .bus_req(BUS_REQUEST_OUT), .delay(arb_delay), .grant(BUS_GRANT_IN));

    initial begin
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic irq_n_exp(input logic [15:0] s, m);
        return ~|(s & m);
    endfunction

    // pin watched by wait_lvl: 0 ack, 1 cycle start, 2 request, 3 local grant
    function automatic logic pick(input int sel);
        case (sel)
            0: return SLAVE_MEM_ACKNOWLEDGE_N;
            1: return EARLY_CYCLE_START_N;
            2: return BUS_REQUEST_OUT;
            default: return LBUF_GNT;
        endcase
    endfunction

    // wait for a level, bounded; leaves us just after an edge
    task automatic wait_lvl(input int sel, input logic v, input int n);
        int i;
        i = 0;
        do begin
            @(posedge CLK_SYS);
            #1;
            i++;
        end while (pick(sel) !== v && i < n);
    endtask

    // ****************************************
    // host and dma transfers
    // ****************************************
    task automatic reg_acc(input logic dir);
        @(posedge CLK_SYS);
        SLAVE_DIR_IN <= dir;
        REG_SELECT_N <= 1'b0;
        REG_READY <= 1'b0;
        repeat (8) @(posedge CLK_SYS);
        #1 chk("ack_not_ready", 1'b1, SLAVE_MEM_ACKNOWLEDGE_N);
        @(posedge CLK_SYS);
        REG_READY <= 1'b1;
        wait_lvl(0, 1'b0, 6);
        chk("ack_ready", 1'b0, SLAVE_MEM_ACKNOWLEDGE_N);
        chk("write_stb", dir, REG_WRITE_STB);
        chk("read_stb", !dir, REG_READ_STB);
        @(posedge CLK_SYS);
        REG_SELECT_N <= 1'b1;
        wait_lvl(0, 1'b1, 6);
        chk("ack_release", 1'b1, SLAVE_MEM_ACKNOWLEDGE_N);
        repeat (HBM_CS_SHARED_MEM_REQUEST_N_GAP + 1) @(posedge CLK_SYS);
    endtask

    task automatic dma_word(input logic ps, wr, input logic [31:0] a,
                            input logic [3:0] dly);
        @(posedge CLK_SYS);
        BUS_PROTOCOL_SELECT <= ps;
        arb_delay <= dly;
        DMA_WRITE <= wr;
        DMA_ADDR <= a;
        DMA_LAST <= 1'b1;
        DMA_REQ <= 1'b1;
        wait_lvl(1, 1'b0, 40);
        chk("ecs_t1", 1'b0, EARLY_CYCLE_START_N);
        chk("ecs_oe", 1'b1, EARLY_CYCLE_START_OE);
        chk("addr_oe", 1'b1, MASTER_ADDR_OE);
        chk("grant_t1", 1'b1, BUS_GRANT_IN);
        chk("req_t1", 1'b1, BUS_REQUEST_OUT);
        chk("ads_t1", 1'b0, ADDR_VALID_STROBE_N);
        chk("dir_t1", wr, MASTER_DIR_STROBE);
        chk("dir_oe", 1'b1, MASTER_DIR_STROBE_OE);
        chk("gack_oe", ps, GRANT_ACK_OUT_OE);
        if (ps) chk("gack_val", 1'b0, GRANT_ACK_OUT_N);
        @(posedge CLK_SYS);
        DMA_REQ <= 1'b0;
        #1 chk("ecs_t2", 1'b1, EARLY_CYCLE_START_N);
        chk("ads_rise", 1'b1, ADDR_VALID_STROBE_N);
        chk("addr_t2", a, MASTER_ADDR);
        wait_lvl(2, 1'b0, 4);
        chk("req_idle", 1'b0, BUS_REQUEST_OUT);
        chk("cycle_done", 1'b1, DMA_CYCLE_DONE);
        chk("oe_off", 1'b0, ADDR_VALID_STROBE_OE);
    endtask

    // ****************************************
    // bus-wide watch and timeout
    // ****************************************
    always @(negedge CLK_SYS) begin
        if (!RESET && LBUF_GNT === 1'b1 && HOST_BUF_GNT === 1'b1)
            chk("one_owner", 1'b0, 1'b1);
        if (!RESET && ADDR_VALID_STROBE_OE === 1'b1 && BUS_GRANT_IN !== 1'b1)
            chk("drive_no_grant", 1'b0, 1'b1);
    end

    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(50));
        repeat (16) @(posedge CLK_SYS);
        RESET <= 1'b0;
        #1 chk("rst_ack", 1'b1, SLAVE_MEM_ACKNOWLEDGE_N);
        chk("rst_req", 1'b0, BUS_REQUEST_OUT);
        chk("rst_int", 1'b1, INTERRUPT_N);
        repeat (3) @(posedge CLK_SYS);
        for (k = 0; k < 24; k++) begin
            ra = (k == 0) ? 32'hffff : (k == 1) ? 32'h8000 : $urandom;
            rb = (k == 0) ? 32'h0 : (k == 1) ? 32'h8000 : $urandom;
            IRQ_STATUS <= ra[15:0];
            IRQ_MASK <= rb[15:0];
            repeat (2) @(posedge CLK_SYS);
            #1 chk("int", irq_n_exp(ra[15:0], rb[15:0]), INTERRUPT_N);
        end
        // frozen clock enable: the pin must keep its last level
        @(posedge CLK_SYS);
        CE <= 1'b0;
        IRQ_STATUS <= ~ra[15:0];
        IRQ_MASK <= 16'hffff;
        repeat (3) @(posedge CLK_SYS);
        #1 chk("int_frozen", irq_n_exp(ra[15:0], rb[15:0]), INTERRUPT_N);
        CE <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        #1 chk("int_thawed", irq_n_exp(~ra[15:0], 16'hffff), INTERRUPT_N);
        $display("test interrupt done");
        for (k = 0; k < 4; k++) begin
            ra = $urandom;
            @(posedge CLK_SYS);
            REG_INDEX_BUS <= ra[5:0];
            @(posedge CLK_SYS);
            SLAVE_INDEX_LATCH_N <= 1'b0;
            repeat (6) @(posedge CLK_SYS);
            SLAVE_INDEX_LATCH_N <= 1'b1;
            #1 chk("index", ra[5:0], REG_INDEX);
            reg_acc(ra[6]);
        end
        $display("test register done");
        @(posedge CLK_SYS);
        LBUF_REQ <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        SHARED_MEM_REQUEST_N <= 1'b0;
        repeat (8) @(posedge CLK_SYS);
        #1 chk("mem_wait", 1'b1, SLAVE_MEM_ACKNOWLEDGE_N);
        chk("local_gnt", 1'b1, LBUF_GNT);
        @(posedge CLK_SYS);
        LBUF_REQ <= 1'b0;
        wait_lvl(0, 1'b0, 8);
        chk("mem_ack", 1'b1, HOST_BUF_GNT);
        @(posedge CLK_SYS);
        LBUF_REQ <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        SHARED_MEM_REQUEST_N <= 1'b1;
        #1 chk("local_held", 1'b0, LBUF_GNT);
        wait_lvl(3, 1'b1, 8);
        chk("local_after", 1'b1, SLAVE_MEM_ACKNOWLEDGE_N);
        @(posedge CLK_SYS);
        LBUF_REQ <= 1'b0;
        $display("test buffer done");
        for (k = 0; k < 6; k++) begin
            ra = $urandom;
            dma_word(k[0], ra[0], $urandom, ra[4:1]);
        end
        $display("test master done");
        end_sim();
    end
endmodule // tb
`default_nettype wire
